// ===== design/iec_regs.sv
// interface and enable control register bank
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "iec_map.svh"

module iec_regs
	import iec_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [7:0] comm_byte_buffer,
	output logic spi_engine_on,
	output logic i2c_engine_on,
	output logic single_wire_interface_on,
	output logic first_dac_on,
	output logic single_wire_transceiver_on,
	output logic first_analog_output_pin_from_dac,
	output logic single_wire_filter_length,
	output logic soft_watchdog_on,
	output logic oscillator_watchdog_on,
	output logic cap_clock_monitor_on,
	output logic dac_loopback_on,
	output logic test_caps_on
);

	// ************************************************************
	// register storage
	// ************************************************************
	logic [7:0] comm_q;
	logic [7:0] dic_q;
	logic [7:0] fen_q;
	logic [7:0] rdata_d;
	logic wr_comm;
	logic wr_dic;
	logic wr_fen;

	// ************************************************************
	// address decode
	// ************************************************************
	// one strobe against one offset, shared by every writable register and by the forwarding paths
	function automatic logic iec_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] offset);
		return strobe && (addr == offset);
	endfunction

	assign wr_comm = iec_hit(reg_wr, reg_addr, `IEC_ADDR_COMM_BYTE_BUFFER);
	assign wr_dic = iec_hit(reg_wr, reg_addr, `IEC_ADDR_DIGITAL_INTERFACE_CONTROL);
	assign wr_fen = iec_hit(reg_wr, reg_addr, `IEC_ADDR_FEATURE_ENABLE);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			comm_q <= `IEC_RST_COMM_BYTE_BUFFER;
		end else if (wr_comm) begin
			comm_q <= reg_wdata;
		end
	end

	// upper bits are read only zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dic_q <= `IEC_RST_DIGITAL_INTERFACE_CONTROL;
		end else if (wr_dic) begin
			dic_q <= reg_wdata & `IEC_DIC_WRITE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fen_q <= `IEC_RST_FEATURE_ENABLE;
		end else if (wr_fen) begin
			fen_q <= reg_wdata & `IEC_FEN_WRITE_MASK;
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	// status word shows the decoded engine selection
	always_comb begin
		unique case (reg_addr)
			`IEC_ADDR_COMM_BYTE_BUFFER: rdata_d = comm_q;
			`IEC_ADDR_DIGITAL_INTERFACE_CONTROL: rdata_d = dic_q;
			`IEC_ADDR_FEATURE_ENABLE: rdata_d = fen_q;
			`IEC_ADDR_STATUS: rdata_d = {4'h0, first_dac_on, single_wire_interface_on, i2c_engine_on, spi_engine_on};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ************************************************************
	// control outputs, registered on the same edge as the write
	// ************************************************************
	iec_sel_t sel_d;
	logic [7:0] fen_d;
	// forwarding the written value keeps the outputs level with the stored copy
	assign fen_d = wr_fen ? (reg_wdata & `IEC_FEN_WRITE_MASK) : fen_q;

	always_comb begin
		if (wr_dic) begin
			sel_d = iec_sel_t'(reg_wdata[`IEC_DIC_SEL_MSB:`IEC_DIC_SEL_LSB]);
		end else begin
			sel_d = iec_sel_t'(dic_q[`IEC_DIC_SEL_MSB:`IEC_DIC_SEL_LSB]);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			spi_engine_on <= 1'b1;
			i2c_engine_on <= 1'b0;
			single_wire_interface_on <= 1'b0;
			first_dac_on <= 1'b1;
		end else begin
			unique case (sel_d)
				IEC_SEL_SPI, IEC_SEL_SPI_ALT: begin
					spi_engine_on <= 1'b1;
					i2c_engine_on <= 1'b0;
					single_wire_interface_on <= 1'b0;
					first_dac_on <= 1'b1;
				end
				IEC_SEL_I2C: begin
					spi_engine_on <= 1'b0;
					i2c_engine_on <= 1'b1;
					single_wire_interface_on <= 1'b0;
					first_dac_on <= 1'b1;
				end
				IEC_SEL_SINGLE_WIRE: begin
					spi_engine_on <= 1'b0;
					i2c_engine_on <= 1'b0;
					single_wire_interface_on <= 1'b1;
					first_dac_on <= 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// shared output pin routing and single wire filter
	// ************************************************************
	// routing and transceiver enable change in one edge so the pin never has two sources
	always_ff @(posedge clk) begin
		if (!nrst) begin
			single_wire_transceiver_on <= 1'h0;
			first_analog_output_pin_from_dac <= 1'h1;
		end else if (wr_dic) begin
			single_wire_transceiver_on <= reg_wdata[`IEC_DIC_XCR_BIT];
			first_analog_output_pin_from_dac <= !reg_wdata[`IEC_DIC_XCR_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			single_wire_filter_length <= 1'h0;
		end else if (wr_dic) begin
			single_wire_filter_length <= reg_wdata[`IEC_DIC_FILTER_BIT];
		end
	end

	// ************************************************************
	// feature enables
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			soft_watchdog_on <= 1'h0;
		end else begin
			soft_watchdog_on <= fen_d[`IEC_FEN_SOFT_WD_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			oscillator_watchdog_on <= 1'h0;
		end else begin
			oscillator_watchdog_on <= fen_d[`IEC_FEN_OSC_WD_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cap_clock_monitor_on <= 1'h0;
		end else begin
			cap_clock_monitor_on <= fen_d[`IEC_FEN_CAP_MON_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			dac_loopback_on <= 1'h0;
		end else begin
			dac_loopback_on <= fen_d[`IEC_FEN_LOOPBACK_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			test_caps_on <= 1'h0;
		end else begin
			test_caps_on <= fen_d[`IEC_FEN_TEST_CAPS_BIT];
		end
	end

	assign comm_byte_buffer = comm_q;

endmodule // iec_regs
`default_nettype wire

// ===== shared/iec_map.svh
// register offsets, field positions and reset values of the interface and enable control bank
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH
`define IEC_ADDR_COMM_BYTE_BUFFER 8'hd3
`define IEC_ADDR_DIGITAL_INTERFACE_CONTROL 8'hd4
`define IEC_ADDR_FEATURE_ENABLE 8'hd5
`define IEC_ADDR_STATUS 8'hd6
`define IEC_RST_COMM_BYTE_BUFFER 8'h00
`define IEC_RST_DIGITAL_INTERFACE_CONTROL 8'h00
`define IEC_RST_FEATURE_ENABLE 8'h00
`define IEC_DIC_WRITE_MASK 8'h0f
`define IEC_FEN_WRITE_MASK 8'h1f
`define IEC_DIC_SEL_LSB 0
`define IEC_DIC_SEL_MSB 1
`define IEC_DIC_XCR_BIT 2
`define IEC_DIC_FILTER_BIT 3
`define IEC_FEN_SOFT_WD_BIT 0
`define IEC_FEN_OSC_WD_BIT 1
`define IEC_FEN_CAP_MON_BIT 2
`define IEC_FEN_LOOPBACK_BIT 3
`define IEC_FEN_TEST_CAPS_BIT 4
`endif

// ===== shared/iec_pkg.sv
// types of the interface and enable control bank
package iec_pkg;
	typedef enum logic [1:0] {
		IEC_SEL_SPI = 2'b00,
		IEC_SEL_I2C = 2'b01,
		IEC_SEL_SINGLE_WIRE = 2'b10,
		IEC_SEL_SPI_ALT = 2'b11
	} iec_sel_t;
endpackage

// ===== testbench/iec_regs_asserts.sv
// assertions on the interface and enable control bank ports
`timescale 1ns/10ps
`default_nettype none
module iec_regs_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic spi_engine_on,
	input wire logic i2c_engine_on,
	input wire logic single_wire_interface_on,
	input wire logic first_dac_on,
	input wire logic single_wire_transceiver_on,
	input wire logic first_analog_output_pin_from_dac,
	input wire logic soft_watchdog_on,
	input wire logic oscillator_watchdog_on,
	input wire logic cap_clock_monitor_on,
	input wire logic dac_loopback_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire w4 = reg_wr && reg_addr == 8'hd4;
	wire w5 = reg_wr && reg_addr == 8'hd5;
	property p_sel;
		w4 |=> single_wire_interface_on == ($past(reg_wdata[1:0]) == 2'h2) && first_dac_on != single_wire_interface_on;
	endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_wd; w5 |=> soft_watchdog_on == $past(reg_wdata[0]); endproperty
	a_wd: assert property (p_wd) else $error("wd");
	property p_osc; w5 |=> oscillator_watchdog_on == $past(reg_wdata[1]); endproperty
	a_osc: assert property (p_osc) else $error("osc");
	property p_mon; w5 |=> cap_clock_monitor_on == $past(reg_wdata[2]); endproperty
	a_mon: assert property (p_mon) else $error("mon");
	property p_lb; w5 |=> dac_loopback_on == $past(reg_wdata[3]); endproperty
	a_lb: assert property (p_lb) else $error("lb");
	property p_xcr;
		w4 |=> single_wire_transceiver_on == $past(reg_wdata[2]) && first_analog_output_pin_from_dac != single_wire_transceiver_on;
	endproperty
	a_xcr: assert property (p_xcr) else $error("xcr");
	property p_eng;
		w4 |=> spi_engine_on == ($past(reg_wdata[1:0]) != 2'h1 && $past(reg_wdata[1:0]) != 2'h2)
			&& i2c_engine_on == ($past(reg_wdata[1:0]) == 2'h1);
	endproperty
	a_eng: assert property (p_eng) else $error("engine select");
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
endmodule // iec_regs_asserts
bind iec_regs iec_regs_asserts chk_u (.*);
`default_nettype wire

// ===== testbench/iec_regs_tb.sv
// testbench of the interface and enable control bank
`timescale 1ns/10ps
`default_nettype none
module iec_regs_tb;
	logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, comm_byte_buffer;
	logic spi_engine_on, i2c_engine_on, single_wire_interface_on, first_dac_on, single_wire_transceiver_on;
	logic first_analog_output_pin_from_dac, single_wire_filter_length, soft_watchdog_on;
	logic oscillator_watchdog_on, cap_clock_monitor_on, dac_loopback_on, test_caps_on;
	int bad_count = 0, compares = 0, cyc = 0;
	logic [7:0] st[4] = '{8'h09, 8'h0a, 8'h04, 8'h09};
	logic [7:0] fen_seen;
	logic [7:0] eng_seen;
	assign fen_seen = {3'h0, test_caps_on, dac_loopback_on, cap_clock_monitor_on, oscillator_watchdog_on, soft_watchdog_on};
	assign eng_seen = {4'h0, first_dac_on, single_wire_interface_on, i2c_engine_on, spi_engine_on};
	iec_regs dut_u (
		.clk(clk),
		.nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.comm_byte_buffer(comm_byte_buffer),
		.spi_engine_on(spi_engine_on),
		.i2c_engine_on(i2c_engine_on),
		.single_wire_interface_on(single_wire_interface_on),
		.first_dac_on(first_dac_on),
		.single_wire_transceiver_on(single_wire_transceiver_on),
		.first_analog_output_pin_from_dac(first_analog_output_pin_from_dac),
		.single_wire_filter_length(single_wire_filter_length),
		.soft_watchdog_on(soft_watchdog_on),
		.oscillator_watchdog_on(oscillator_watchdog_on),
		.cap_clock_monitor_on(cap_clock_monitor_on),
		.dac_loopback_on(dac_loopback_on),
		.test_caps_on(test_caps_on)
	);
	always #10 clk = ~clk;
	task automatic chk(string n, logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, d);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk) reg_wr <= 0;
		@(posedge clk);
	endtask
	task automatic rd(logic [7:0] a, e, string n);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk) reg_rd <= 0;
		#1 chk(n, reg_rdata, e);
		@(posedge clk);
	endtask
	always @(posedge clk) if (++cyc == 3000) begin
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge clk);
		chk("rst eng", eng_seen, 8'h09);
		chk("rst fen", fen_seen, 8'h00);
		chk("rst pin", 8'(first_analog_output_pin_from_dac), 8'h01);
		chk("rst xcr", 8'({single_wire_transceiver_on, single_wire_filter_length}), 8'h00);
		chk("rst rd", reg_rdata, 8'h00);
		chk("rst cbb", comm_byte_buffer, 8'h00);
		nrst <= 1'h1;
		@(posedge clk);
		rd(8'hd3, 8'h00, "cbb");
		rd(8'hd4, 8'h00, "dic");
		rd(8'hd5, 8'h00, "fen");
		rd(8'hd6, 8'h09, "stat");
		for (int i = 0; i < 4; i++) begin
			wr(8'hd4, 8'(i));
			chk("eng", eng_seen, st[i]);
			rd(8'hd6, st[i], "stat");
		end
		wr(8'hd4, 8'hff);
		rd(8'hd4, 8'h0f, "dic");
		chk("xcr on", 8'(single_wire_transceiver_on), 8'h01);
		chk("pin on", 8'(first_analog_output_pin_from_dac), 8'h00);
		chk("filter", 8'(single_wire_filter_length), 8'h01);
		wr(8'hd4, 8'h03);
		chk("xcr off", 8'(single_wire_transceiver_on), 8'h00);
		chk("pin off", 8'(first_analog_output_pin_from_dac), 8'h01);
		chk("filter off", 8'(single_wire_filter_length), 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(8'hd5, 8'h01 << i);
			chk("fen", fen_seen, 8'h01 << i);
		end
		wr(8'hd5, 8'hff);
		rd(8'hd5, 8'h1f, "fen");
		wr(8'hd3, 8'ha5);
		rd(8'hd3, 8'ha5, "cbb");
		chk("cbb", comm_byte_buffer, 8'ha5);
		wr(8'hd7, 8'hff);
		rd(8'hd7, 8'h00, "unm");
		rd(8'hd3, 8'ha5, "cbb keep");
		wr(8'hd4, 8'h06);
		chk("eng sw", eng_seen, 8'h04);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		chk("mid eng", eng_seen, 8'h09);
		chk("mid fen", fen_seen, 8'h00);
		chk("mid pin", 8'(first_analog_output_pin_from_dac), 8'h01);
		chk("mid xcr", 8'(single_wire_transceiver_on), 8'h00);
		nrst <= 1'h1;
		@(posedge clk);
		rd(8'hd3, 8'h00, "cbb mid");
		rd(8'hd4, 8'h00, "dic mid");
		rd(8'hd5, 8'h00, "fen mid");
		chk("cbb mid", comm_byte_buffer, 8'h00);
		tally_and_finish;
	end
endmodule // iec_regs_tb
`default_nettype wire
